/* File: dsg_pkg.sv */
// Package of constants and types for the deep-sleep clock gating bank
package dsg_pkg;

   // ==========================================================
   // Register map (byte offsets within the system control block)
   localparam logic [11:0] RUN_GATE_OFS = 12'h104;
   localparam logic [11:0] SLEEP_GATE_OFS = 12'h114;
   localparam logic [11:0] DEEP_GATE_OFS = 12'h124;
   localparam logic [11:0] CLK_CFG_OFS = 12'h060;
   localparam logic [11:0] IRQ_STAT_OFS = 12'h140;
   localparam logic [11:0] IRQ_MASK_OFS = 12'h144;

   // ==========================================================
   // Field layouts and reset values
   localparam logic [31:0] GATE_RESET = 32'h0000_0000;
   localparam logic [31:0] GATE_WMASK = 32'h000f_5017;
   localparam logic [31:0] CFG_RESET = 32'h0000_0000;
   localparam logic [31:0] CFG_WMASK = 32'h0000_0001;
   localparam int AUTO_GATE_BIT = 0;
   localparam logic [31:0] IRQ_RESET = 32'h0000_0000;
   localparam logic [31:0] IRQ_WMASK = 32'h0000_0003;
   localparam int EV_FAULT_BIT = 0;
   localparam int EV_MODE_BIT = 1;
   localparam int NUM_UNITS = 10;

   // ==========================================================
   // Power states, Gray coded along run -> sleep -> deep sleep
   typedef enum logic [1:0] {
      PM_RUN = 2'b00,
      PM_SLEEP = 2'b01,
      PM_DEEP = 2'b11
   } power_mode_t;

   // Unit index to gating bit: timers 0..3, i2c 0..1, serial, uart 0..2
   function automatic int unit_pos(input int idx);
      case (idx)
         0: unit_pos = 16;
         1: unit_pos = 17;
         2: unit_pos = 18;
         3: unit_pos = 19;
         4: unit_pos = 12;
         5: unit_pos = 14;
         6: unit_pos = 4;
         7: unit_pos = 0;
         8: unit_pos = 1;
         default: unit_pos = 2;
      endcase
   endfunction

endpackage

/* File: clk_gate_cell.sv */
// Glitch-free latch-based clock gate for one peripheral unit
`timescale 1ns/1ns
`default_nettype none
module clk_gate_cell (
   input wire logic clk,
   input wire logic en,
   output logic gclk
);

   logic en_lat;

   // Enable is captured while the clock is low, so the AND never slivers
   always_latch begin
      if (!clk) begin
         en_lat <= en;
      end
   end

   assign gclk = clk & en_lat;

endmodule // clk_gate_cell
`default_nettype wire

/* File: deep_sleep_clock_gating_bank1.sv */
// Clock gating bank 1: run, sleep and deep-sleep gates, fault checking
//
// Overview of operation
// RULE1: Set bit clocks unit, clear bit stops it
// RULE2: Access to gated unit answers bus fault
// RULE3: Deep-sleep gate register resets to zero
// RULE4: Deep-sleep register at 0x124, used in deep sleep
// RULE5: Sleep copies apply only with auto gating
// RULE6: Bits 19..16 enable timers 3..0
// RULE7: Bit 14 second i2c, bit 12 first
// RULE8: Bit 4 enables synchronous serial unit
// RULE9: Bits 2..0 enable uarts 2..0
// RULE10: Reserved bits read zero, writes ignored
// RULE11: Power state selects copy, drives clock gate
//
// Chosen here: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
module deep_sleep_clock_gating_bank1
   import dsg_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic [11:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [31:0] rdata_q,
   input wire logic [1:0] power_mode,
   input wire logic per_req,
   input wire logic [3:0] per_unit,
   output logic per_ok_q,
   output logic per_fault_q,
   output logic [NUM_UNITS-1:0] unit_clk_en_q,
   output logic [NUM_UNITS-1:0] unit_clk,
   output logic irq_q
);

   // ==========================================================
   // Declarations
   logic [31:0] run_clock_gate_1_q;
   logic [31:0] sleep_clock_gate_1_q;
   logic [31:0] deep_sleep_clock_gate_1_q;
   logic [31:0] run_clock_config_q;
   logic [31:0] irq_stat_q;
   logic [31:0] irq_stat_d;
   logic [31:0] irq_mask_q;
   logic [31:0] irq_mask_d;
   logic [31:0] sel_gate;
   logic [31:0] rdata_d;
   logic [NUM_UNITS-1:0] unit_en;
   logic [1:0] prev_mode_q;
   logic auto_gating_select;
   logic unit_valid;
   logic unit_on;
   logic [31:0] events;

   // Decode of one unit's enable from a gate vector, index checked
   function automatic logic gate_of(input logic [NUM_UNITS-1:0] en,
                                    input logic [3:0] idx);
      logic r;
      r = 1'b0;
      for (int i = 0; i < NUM_UNITS; i++) begin
         if (idx == 4'(i)) begin
            r = en[i];
         end
      end
      return r;
   endfunction

   // ==========================================================
   // Register writes

   // Run-mode gate copy; reserved bits are never stored
   always_ff @(posedge clk) begin
      if (srst) begin
         run_clock_gate_1_q <= GATE_RESET;
      end else if (wr_en && addr == RUN_GATE_OFS) begin
         run_clock_gate_1_q <= wdata & GATE_WMASK;
      end
   end

   // Sleep-mode gate copy
   always_ff @(posedge clk) begin
      if (srst) begin
         sleep_clock_gate_1_q <= GATE_RESET;
      end else if (wr_en && addr == SLEEP_GATE_OFS) begin
         sleep_clock_gate_1_q <= wdata & GATE_WMASK;
      end
   end

   // RULE3 zero at reset
   // RULE4 deep-sleep decode
   // RULE10 reserved masked off
   always_ff @(posedge clk) begin
      if (srst) begin
         deep_sleep_clock_gate_1_q <= GATE_RESET;
      end else if (wr_en && addr == DEEP_GATE_OFS) begin
         deep_sleep_clock_gate_1_q <= wdata & GATE_WMASK;
      end
   end

   // Run clock configuration; only the auto gating bit is kept here
   always_ff @(posedge clk) begin
      if (srst) begin
         run_clock_config_q <= CFG_RESET;
      end else if (wr_en && addr == CLK_CFG_OFS) begin
         run_clock_config_q <= wdata & CFG_WMASK;
      end
   end

   // Mask next value, so the interrupt follows a mask write at once
   always_comb begin
      irq_mask_d = irq_mask_q;
      if (wr_en && addr == IRQ_MASK_OFS) begin
         irq_mask_d = wdata & IRQ_WMASK;
      end
   end

   // Interrupt mask, same layout as the status register
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_mask_q <= IRQ_RESET;
      end else begin
         irq_mask_q <= irq_mask_d;
      end
   end

   assign auto_gating_select = run_clock_config_q[AUTO_GATE_BIT];

   // ==========================================================
   // Copy selection by power state

   // RULE5 auto gating gate
   // RULE11 state picks copy
   always_comb begin
      sel_gate = run_clock_gate_1_q;
      if (auto_gating_select) begin
         case (power_mode)
            PM_SLEEP: sel_gate = sleep_clock_gate_1_q;
            PM_DEEP: sel_gate = deep_sleep_clock_gate_1_q;
            default: sel_gate = run_clock_gate_1_q;
         endcase
      end
   end

   // ==========================================================
   // Per-unit enables and clock gates
   generate
      for (genvar g = 0; g < NUM_UNITS; g++) begin : g_unit
         // RULE6 timer bits
         // RULE7 i2c bits
         // RULE8 serial bit
         // RULE9 uart bits
         assign unit_en[g] = sel_gate[unit_pos(g)];

         // RULE1 unit clock enable
         always_ff @(posedge clk) begin
            if (srst) begin
               unit_clk_en_q[g] <= 1'b0;
            end else begin
               unit_clk_en_q[g] <= unit_en[g];
            end
         end

         // RULE11 glitch-free gate
         clk_gate_cell u_gate (
            .clk(clk),
            .en(unit_clk_en_q[g]),
            .gclk(unit_clk[g])
         );
      end
   endgenerate

   // ==========================================================
   // Peripheral access checking

   // Unknown unit indexes are faulted too, so stray decodes never hang
   assign unit_valid = (per_unit < 4'(NUM_UNITS));
   assign unit_on = unit_valid && gate_of(unit_clk_en_q, per_unit);

   // RULE2 fault on gated unit
   always_ff @(posedge clk) begin
      if (srst) begin
         per_ok_q <= 1'b0;
         per_fault_q <= 1'b0;
      end else begin
         per_ok_q <= per_req && unit_on;
         per_fault_q <= per_req && !unit_on;
      end
   end

   // ==========================================================
   // Interrupt events and status

   // Remember the power state to spot transitions
   always_ff @(posedge clk) begin
      if (srst) begin
         prev_mode_q <= PM_RUN;
      end else begin
         prev_mode_q <= power_mode;
      end
   end

   always_comb begin
      events = 32'h0;
      events[EV_FAULT_BIT] = per_req && !unit_on;
      events[EV_MODE_BIT] = (power_mode != prev_mode_q);
   end

   // Write one to clear; a new event in the same cycle wins
   always_comb begin
      irq_stat_d = irq_stat_q;
      if (wr_en && addr == IRQ_STAT_OFS) begin
         irq_stat_d = irq_stat_q & ~(wdata & IRQ_WMASK);
      end
      irq_stat_d = irq_stat_d | (events & IRQ_WMASK);
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_q <= IRQ_RESET;
      end else begin
         irq_stat_q <= irq_stat_d;
      end
   end

   // Level interrupt from a flop, fed by next status and next mask so
   // that it never lags the registers software can read
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(irq_stat_d & irq_mask_d);
      end
   end

   // ==========================================================
   // Read path

   // RULE10 reserved read zero
   always_comb begin
      rdata_d = 32'h0;
      case (addr)
         RUN_GATE_OFS: rdata_d = run_clock_gate_1_q;
         SLEEP_GATE_OFS: rdata_d = sleep_clock_gate_1_q;
         DEEP_GATE_OFS: rdata_d = deep_sleep_clock_gate_1_q;
         CLK_CFG_OFS: rdata_d = run_clock_config_q;
         IRQ_STAT_OFS: rdata_d = irq_stat_q;
         IRQ_MASK_OFS: rdata_d = irq_mask_q;
         default: rdata_d = 32'h0;
      endcase
   end

   // Data valid only the cycle after the strobe; zero otherwise
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_q <= 32'h0;
      end else if (rd_en) begin
         rdata_q <= rdata_d;
      end else begin
         rdata_q <= 32'h0;
      end
   end

   // ==========================================================
   // Assertions
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (srst);

   // RULE3 reset value
   chk_reset_zero: assert property ( // RULE3
      @(posedge clk) disable iff (1'b0)
      srst |=> deep_sleep_clock_gate_1_q == GATE_RESET)
      else $error("deep gate not zero after reset");

   // RULE4 write at offset
   chk_deep_write: assert property ( // RULE4
      wr_en && addr == DEEP_GATE_OFS
      |=> deep_sleep_clock_gate_1_q == ($past(wdata) & GATE_WMASK))
      else $error("deep gate write not stored");

   // RULE10 reserved bits
   chk_reserved_zero: assert property ( // RULE10
      (deep_sleep_clock_gate_1_q & ~GATE_WMASK) == 32'h0)
      else $error("reserved deep gate bits set");

   // RULE2 fault answer
   chk_fault_gated: assert property ( // RULE2
      per_req && !unit_on |=> per_fault_q && !per_ok_q)
      else $error("gated unit access not faulted");

   // RULE1 normal completion
   chk_ok_enabled: assert property ( // RULE1
      per_req && unit_valid && unit_clk_en_q[0] && per_unit == 4'h0
      |=> per_ok_q && !per_fault_q)
      else $error("enabled unit access faulted");

   // RULE11 deep copy selected
   chk_select_deep: assert property ( // RULE11
      auto_gating_select && power_mode == PM_DEEP
      |=> unit_clk_en_q[6] == $past(deep_sleep_clock_gate_1_q[4]))
      else $error("deep copy not driving serial gate");

   // RULE5 run copy without auto gating
   chk_no_auto_run: assert property ( // RULE5
      !auto_gating_select
      |=> unit_clk_en_q[3] == $past(run_clock_gate_1_q[19]))
      else $error("run copy ignored without auto gating");

   // RULE6 timer bits map
   chk_timer_map: assert property ( // RULE6
      auto_gating_select && power_mode == PM_DEEP
      |=> unit_clk_en_q[3:0] == $past(deep_sleep_clock_gate_1_q[19:16]))
      else $error("timer enables misrouted");

   // RULE9 uart bits map
   chk_uart_map: assert property ( // RULE9
      !auto_gating_select
      |=> unit_clk_en_q[9:7] == $past(run_clock_gate_1_q[2:0]))
      else $error("uart enables misrouted");

   // RULE7 i2c bits map
   chk_i2c_map: assert property ( // RULE7
      auto_gating_select && power_mode == PM_SLEEP
      |=> unit_clk_en_q[5:4] == {$past(sleep_clock_gate_1_q[14]),
                                 $past(sleep_clock_gate_1_q[12])})
      else $error("i2c enables misrouted");

   // RULE4 read back
   chk_read_back: assert property ( // RULE4
      rd_en && addr == DEEP_GATE_OFS
      |=> rdata_q == $past(deep_sleep_clock_gate_1_q)
      ##1 ($past(rd_en) || rdata_q == 32'h0))
      else $error("deep gate read back wrong");

   chk_irq_level: assert property (
      irq_q == |(irq_stat_q & irq_mask_q))
      else $error("interrupt level differs from masked status");

   cov_deep_fault: cover property (
      auto_gating_select && power_mode == PM_DEEP && per_req && !unit_on);
   cov_deep_ok: cover property (
      auto_gating_select && power_mode == PM_DEEP && per_req && unit_on);
   cov_irq_raise: cover property ($rose(irq_q));
   cov_sleep_on: cover property (
      auto_gating_select && power_mode == PM_SLEEP && |unit_clk_en_q);

endmodule // deep_sleep_clock_gating_bank1
`default_nettype wire

/* File: tb_top.sv */
// Self-checking bench for the deep-sleep clock gating bank
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import dsg_pkg::*;
;
   logic clk, srst, wr_en, rd_en, per_req, irq_q, per_ok_q, per_fault_q;
   logic [11:0] addr;
   logic [31:0] wdata, rdata_q, v;
   logic [1:0] power_mode;
   logic [3:0] per_unit;
   logic [NUM_UNITS-1:0] unit_clk_en_q, unit_clk, exp_en;
   logic [31:0] run_v, slp_v, dp_v;
   logic [1:0] modes [4] = '{2'b00, 2'b01, 2'b11, 2'b10};
   int pos [10] = '{16, 17, 18, 19, 12, 14, 4, 0, 1, 2};
   int n_mismatch = 0;
   int n_compared = 0;
   int seed = 40050;

   deep_sleep_clock_gating_bank1 uut (
      .clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
      .wr_en(wr_en), .rd_en(rd_en), .rdata_q(rdata_q),
      .power_mode(power_mode), .per_req(per_req), .per_unit(per_unit),
      .per_ok_q(per_ok_q), .per_fault_q(per_fault_q),
      .unit_clk_en_q(unit_clk_en_q), .unit_clk(unit_clk), .irq_q(irq_q)
   );

   // ==========================================================
   // Helpers
   // Expected enables: deep or sleep copy only under auto gating
   function automatic logic [9:0] sel_en(input logic auto, logic [1:0] m);
      logic [31:0] s;
      s = (auto && m == 2'b01) ? slp_v : (auto && m == 2'b11) ? dp_v : run_v;
      for (int i = 0; i < 10; i++) sel_en[i] = s[pos[i]];
   endfunction

   task automatic check(input string name, logic [31:0] exp, got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic wr(input logic [11:0] a, logic [31:0] d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [11:0] a, logic [31:0] exp, string nm);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      check(nm, exp, rdata_q);
   endtask

   // Answer comes one cycle after the request edge
   task automatic access(input int u);
      logic ok;
      ok = (u < 10) ? exp_en[u] : 1'b0;
      @(posedge clk);
      per_req <= 1'b1;
      per_unit <= u[3:0];
      @(posedge clk);
      per_req <= 1'b0;
      #1;
      check("per_ok", ok, per_ok_q);
      check("per_fault", !ok, per_fault_q);
   endtask

   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ==========================================================
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Whole run needs a few hundred cycles; this margin is generous
   initial begin
      repeat (20000) @(posedge clk);
      n_mismatch++;
      $display("watchdog expired");
      finish_test;
   end

   // ==========================================================
   // Main sequence
   initial begin
      srst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; per_req = 1'b0;
      addr = 12'h000; wdata = 32'h0; power_mode = 2'b00; per_unit = 4'h0;
      run_v = 32'h0; slp_v = 32'h0; dp_v = 32'h0; exp_en = '0;
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      rd(DEEP_GATE_OFS, GATE_RESET, "deep reset");
      rd(RUN_GATE_OFS, GATE_RESET, "run reset");
      rd(SLEEP_GATE_OFS, GATE_RESET, "sleep reset");
      check("en reset", 32'h0, {22'h0, unit_clk_en_q});
      // Corner patterns first, then random words
      for (int i = 0; i < 10; i++) begin
         v = (i == 0) ? 32'hffff_ffff : (i == 1) ? ~GATE_WMASK : $random(seed);
         wr(DEEP_GATE_OFS, v);
         rd(DEEP_GATE_OFS, v & GATE_WMASK, "deep");
      end
      // Unmapped place must neither answer nor alias the gate
      wr(12'h128, 32'hffff_ffff);
      rd(12'h128, 32'h0, "unmapped");
      rd(DEEP_GATE_OFS, v & GATE_WMASK, "deep kept");
      // Every power mode with and without auto gating
      for (int k = 0; k < 8; k++) begin
         run_v = $random(seed) & GATE_WMASK;
         slp_v = $random(seed) & GATE_WMASK;
         dp_v = $random(seed) & GATE_WMASK;
         wr(RUN_GATE_OFS, run_v);
         wr(SLEEP_GATE_OFS, slp_v);
         wr(DEEP_GATE_OFS, dp_v);
         wr(CLK_CFG_OFS, {31'h0, k[0]});
         power_mode <= modes[k >> 1];
         exp_en = sel_en(k[0], modes[k >> 1]);
         step(3);
         check("enable", {22'h0, exp_en}, {22'h0, unit_clk_en_q});
         @(posedge clk);
         #10;
         check("gclk high", {22'h0, exp_en}, {22'h0, unit_clk});
         @(negedge clk);
         #10;
         check("gclk low", 32'h0, {22'h0, unit_clk});
         for (int u = 0; u < 12; u++) access(u);
      end
      // Fault event, masked then unmasked, then cleared
      run_v = 32'h0;
      wr(RUN_GATE_OFS, 32'h0);
      wr(IRQ_MASK_OFS, 32'h0);
      wr(IRQ_STAT_OFS, 32'h3);
      exp_en = '0;
      step(2);
      rd(IRQ_STAT_OFS, 32'h0, "stat clr");
      access(6);
      step(1);
      check("irq masked", 32'h0, irq_q);
      rd(IRQ_STAT_OFS, 32'h1, "stat fault");
      wr(IRQ_MASK_OFS, 32'h1);
      wr(IRQ_STAT_OFS, 32'h1);
      step(2);
      check("irq idle", 32'h0, irq_q);
      access(7);
      step(1);
      check("irq fault", 32'h1, irq_q);
      wr(IRQ_STAT_OFS, 32'h1);
      step(2);
      check("irq cleared", 32'h0, irq_q);
      // Mode change event
      wr(IRQ_MASK_OFS, 32'h2);
      power_mode <= 2'b01;
      step(3);
      rd(IRQ_STAT_OFS, 32'h2, "stat mode");
      check("irq mode", 32'h1, irq_q);
      // Reset in mid-run clears the gate
      wr(DEEP_GATE_OFS, 32'hffff_ffff);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd(DEEP_GATE_OFS, GATE_RESET, "deep rerst");
      check("en rerst", 32'h0, {22'h0, unit_clk_en_q});
      check("irq rerst", 32'h0, irq_q);
      finish_test;
   end
endmodule // tb_top
`default_nettype wire
